// *** dpbfb_pkg.sv ***
package dpbfb_pkg;

  // Width of each port data bus and of every data register.
  localparam int unsigned DATA_W = 18;

  // Default depth of each direction; the smaller variant uses 256.
  localparam int unsigned DEPTH = 512;

  // Pointer width matching the default depth.
  localparam int unsigned ADDR_W = 9;

  // Offset field width inside each 18-bit flag offset register.
  localparam int unsigned OFF_W = 9;

  // Every flag offset comes out of reset at eight words.
  localparam logic [OFF_W-1:0] OFF_RESET = 9'h008;

  // Port-A resource select codes.
  localparam int unsigned SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_FIFO = 3'h0;
  localparam logic [SEL_W-1:0] SEL_BYPASS = 3'h1;

  // A set top select bit picks a flag offset register (1XX).
  localparam int unsigned SEL_OFF_BIT = 2;

  // Low select bits that index the offset register bank.
  localparam int unsigned OFF_IDX_W = 2;

  // Number of flag offset registers.
  localparam int unsigned OFF_COUNT = 4;

  // Index of each flag offset register within the bank.
  typedef enum logic [OFF_IDX_W-1:0] {
    OFF_AB_AE = 2'h0,
    OFF_AB_AF = 2'h1,
    OFF_BA_AE = 2'h2,
    OFF_BA_AF = 2'h3
  } dpbfb_off_sel_t;

endpackage : dpbfb_pkg

// *** dpbfb_fifo.sv ***
`timescale 1ns/1ns
module dpbfb_fifo #(
  parameter int unsigned DEPTH = dpbfb_pkg::DEPTH,
  parameter int unsigned AW = dpbfb_pkg::ADDR_W,
  parameter int unsigned DW = dpbfb_pkg::DATA_W,
  parameter int unsigned OW = dpbfb_pkg::OFF_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  output logic [DW-1:0] rd_data,
  input wire logic [OW-1:0] ae_off,
  input wire logic [OW-1:0] af_off,
  output logic empty_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic full_n
);

  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);
  localparam logic [AW:0] ONE_C = (AW + 1)'(1);

  logic [DW-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic do_wr;
  logic do_rd;

  // A full buffer refuses writes and an empty one refuses reads, so the count never wraps.
  assign do_wr = wr_en & (count_q != DEPTH_C);
  assign do_rd = rd_en & (count_q != '0);
  assign rd_data = mem_q[rptr_q];

  // Occupancy after this cycle's push and pop.
  always_comb begin
    count_d = count_q;
    if (do_wr && !do_rd) begin
      count_d = count_q + ONE_C;
    end else if (do_rd && !do_wr) begin
      count_d = count_q - ONE_C;
    end
  end

  // Storage has no reset; only pointers and count define its contents.
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wptr_q] <= wr_data;
    end
  end

  // Pointers return to the first location on either reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else if (clear) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_wr) begin
        wptr_q <= (wptr_q == LAST_C) ? '0 : wptr_q + 1'b1;
      end
      if (do_rd) begin
        rptr_q <= (rptr_q == LAST_C) ? '0 : rptr_q + 1'b1;
      end
      count_q <= count_d;
    end
  end

  // Flags are registered from the next count so they agree with count_q in every cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      empty_n <= 1'b0;
      almost_empty_n <= 1'b0;
      almost_full_n <= 1'b1;
      full_n <= 1'b1;
    end else if (clear) begin
      empty_n <= 1'b0;
      almost_empty_n <= 1'b0;
      almost_full_n <= 1'b1;
      full_n <= 1'b1;
    end else begin
      empty_n <= (count_d != '0);
      almost_empty_n <= (count_d > (AW + 1)'(ae_off));
      almost_full_n <= (count_d < (DEPTH_C - (AW + 1)'(af_off)));
      full_n <= (count_d != DEPTH_C);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  fifo_full_a: assert property (count_q == DEPTH_C |-> !full_n && !almost_full_n)
    else $error("full count without full flag");
  fifo_empty_a: assert property (count_q == '0 |-> !empty_n && !almost_empty_n)
    else $error("empty count without empty flag");
  almost_empty_a: assert property (count_q <= (AW + 1)'(ae_off) && $stable(ae_off) |-> !almost_empty_n)
    else $error("almost-empty flag high at or below offset");
  read_pop_a: assert property (rd_en && !wr_en && !clear && count_q != '0 |=> count_q == $past(count_q) - ONE_C)
    else $error("read did not advance the read side");

endmodule : dpbfb_fifo

// *** dpbfb_top.sv ***
`timescale 1ns/1ns
// Summary of operation
// - Port-A read, select 000, loads next B-to-A word and advances the read pointer.
// - Port-A read, select 001, returns the port-B input register over bypass.
// - Port-A read, select 1XX, returns the addressed flag offset register.
// - Port-A access without enable holds output register and read pointer.
// - Deasserted port-A select forces bypass indicator high and ends bypass.
// - Bypass write loads port-A input register, drops A-to-B full, blocks further writes.
// - A-to-B empty rises next B edge; port-B read takes word, empty falls.
// - After port B takes the word, A-to-B full returns high next A edge.
// - Port-B to port-A bypass works the same with B-to-A flags.
// - Select change 001 to 000 raises bypass indicator at next B edge.
// - Port A responds only while its active-low select is low.
// - Write on rnw and enable low; rnw high, output enable low drives bus.
// - Select decodes FIFO, bypass and the four flag offset registers.
// - Each direction has empty, almost-empty, almost-full and full flags.
// - Every flag offset is eight after reset.
// - Each flag is updated on the clock of the side that watches it.
// - A flag updates on the current port edge, or slips one edge.
// - Port B works regardless of port-A select, writing and reading its FIFO.
// - Offset registers are 18 bits with offset in bits 8..0, rest ignored.
// - Almost-empty low up to n words; almost-full low from D-m words.
// - Reset clears empty flags, sets full flags, homes all pointers.
module dpbfb_top #(
  parameter int unsigned DEPTH = dpbfb_pkg::DEPTH,
  parameter int unsigned AW = dpbfb_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic device_reset_n,
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_read_not_write,
  input wire logic port_a_enable_n,
  input wire logic port_a_output_enable_n,
  input wire logic [dpbfb_pkg::SEL_W-1:0] port_a_resource_select,
  input wire logic [dpbfb_pkg::DATA_W-1:0] port_a_data_bus_in,
  output logic [dpbfb_pkg::DATA_W-1:0] port_a_data_bus_out,
  output logic port_a_data_bus_oe,
  input wire logic port_b_clock,
  input wire logic port_b_read_not_write,
  input wire logic port_b_enable_n,
  input wire logic port_b_output_enable_n,
  input wire logic [dpbfb_pkg::DATA_W-1:0] port_b_data_bus_in,
  output logic [dpbfb_pkg::DATA_W-1:0] port_b_data_bus_out,
  output logic port_b_data_bus_oe,
  output logic bypass_indicator_n,
  output logic ab_empty_n,
  output logic ab_almost_empty_n,
  output logic ab_almost_full_n,
  output logic ab_full_n,
  output logic ba_empty_n,
  output logic ba_almost_empty_n,
  output logic ba_almost_full_n,
  output logic ba_full_n
);

  localparam int unsigned DW = dpbfb_pkg::DATA_W;
  localparam int unsigned OW = dpbfb_pkg::OFF_W;
  localparam int unsigned IW = dpbfb_pkg::OFF_IDX_W;
  localparam int unsigned SYNC_W = 13 + 2 * DW;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and port clock edge detection.

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic dev_rst_n_s, port_a_clock_s, cs_n_s, rnw_a_s, en_a_n_s, oe_a_n_s;
  logic [dpbfb_pkg::SEL_W-1:0] sel_s;
  logic [DW-1:0] da_s;
  logic port_b_clock_s, rnw_b_s, en_b_n_s, oe_b_n_s;
  logic [DW-1:0] db_s;
  logic port_a_clock_prev_q;
  logic port_b_clock_prev_q;
  logic a_rise, b_rise;

  // All pins, data included, travel the same two stages so controls and data stay aligned.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {device_reset_n, port_a_clock, port_a_select_n, port_a_read_not_write, port_a_enable_n,
                  port_a_output_enable_n, port_a_resource_select, port_a_data_bus_in, port_b_clock,
                  port_b_read_not_write, port_b_enable_n, port_b_output_enable_n, port_b_data_bus_in};
      sync2_q <= sync1_q;
    end
  end

  assign {dev_rst_n_s, port_a_clock_s, cs_n_s, rnw_a_s, en_a_n_s, oe_a_n_s, sel_s, da_s,
          port_b_clock_s, rnw_b_s, en_b_n_s, oe_b_n_s, db_s} = sync2_q;

  // Previous levels reset high, yet the synchronisers reset low, so a clock pin that is high at reset is taken as an edge once it arrives.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_a_clock_prev_q <= 1'b1;
      port_b_clock_prev_q <= 1'b1;
    end else begin
      port_a_clock_prev_q <= port_a_clock_s;
      port_b_clock_prev_q <= port_b_clock_s;
    end
  end

  assign a_rise = port_a_clock_s & ~port_a_clock_prev_q;
  assign b_rise = port_b_clock_s & ~port_b_clock_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Access decode for both ports.

  logic soft_clr, a_act, a_wr, a_rd, b_wr, b_rd;
  logic sel_fifo, sel_byp, sel_off, a_byp_now, bypass_b;
  logic [IW-1:0] off_idx;

  assign soft_clr = ~dev_rst_n_s;
  assign a_act = ~cs_n_s;
  assign a_wr = a_rise & a_act & ~rnw_a_s & ~en_a_n_s;
  assign a_rd = a_rise & a_act & rnw_a_s & ~en_a_n_s;
  assign b_wr = b_rise & ~rnw_b_s & ~en_b_n_s;
  assign b_rd = b_rise & rnw_b_s & ~en_b_n_s;
  assign sel_fifo = (sel_s == dpbfb_pkg::SEL_FIFO);
  assign sel_byp = (sel_s == dpbfb_pkg::SEL_BYPASS);
  assign sel_off = sel_s[dpbfb_pkg::SEL_OFF_BIT];
  assign off_idx = sel_s[IW-1:0];
  assign a_byp_now = a_act & sel_byp;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag offset registers.

  logic [OW-1:0] offs_q [dpbfb_pkg::OFF_COUNT];

  // Only the low offset bits are kept; the upper bits of the write are dropped.
  for (genvar i = 0; i < dpbfb_pkg::OFF_COUNT; i++) begin : g_off
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        offs_q[i] <= dpbfb_pkg::OFF_RESET;
      end else if (soft_clr) begin
        offs_q[i] <= dpbfb_pkg::OFF_RESET;
      end else if (a_wr && sel_off && off_idx == IW'(i)) begin
        offs_q[i] <= da_s[OW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bypass mode and indicator.

  logic bypass_a_q, byp_n_q, byp_n_d, byp_clr;

  // Port-A mode follows the select at each A edge, and drops at once when the chip select rises.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bypass_a_q <= 1'b0;
    end else if (cs_n_s) begin
      bypass_a_q <= 1'b0;
    end else if (a_rise) begin
      bypass_a_q <= sel_byp;
    end
  end

  // The indicator follows port-A mode on B edges so port B sees it in its own clock; a deselect raises it at once.
  always_comb begin
    byp_n_d = byp_n_q;
    if (cs_n_s) begin
      byp_n_d = 1'b1;
    end else if (b_rise) begin
      byp_n_d = ~bypass_a_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byp_n_q <= 1'b1;
    end else begin
      byp_n_q <= byp_n_d;
    end
  end

  assign bypass_b = ~byp_n_q;
  // Leaving bypass discards any word not yet taken; the far side must avoid that.
  assign byp_clr = soft_clr | (byp_n_d & ~byp_n_q);

  ////////////////////////////////////////////////////////////////////////////////
  // One-word bypass handshakes in each direction.

  logic [DW-1:0] a_in_q, b_in_q;
  logic ab_byp_full_q, ab_byp_avail_q, ab_byp_taken_q, ab_byp_wr, ab_byp_rd;
  logic ba_byp_full_q, ba_byp_avail_q, ba_byp_taken_q, ba_byp_wr, ba_byp_rd;

  assign ab_byp_wr = a_wr & a_byp_now & ~ab_byp_full_q;
  assign ab_byp_rd = b_rd & bypass_b & ab_byp_avail_q;
  assign ba_byp_wr = b_wr & bypass_b & ~ba_byp_full_q;
  assign ba_byp_rd = a_rd & a_byp_now & ba_byp_avail_q;

  // Input registers; a pending bypass word blocks a new bypass load on its own side.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_in_q <= '0;
      b_in_q <= '0;
    end else begin
      if (a_wr && !(a_byp_now && ab_byp_full_q)) begin
        a_in_q <= da_s;
      end
      if (b_wr && !(bypass_b && ba_byp_full_q)) begin
        b_in_q <= db_s;
      end
    end
  end

  // A-to-B: full on A side; offered from the B edge that lowers the indicator; taken frees full on next A edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ab_byp_full_q <= 1'b0;
      ab_byp_avail_q <= 1'b0;
      ab_byp_taken_q <= 1'b0;
    end else if (byp_clr) begin
      ab_byp_full_q <= 1'b0;
      ab_byp_avail_q <= 1'b0;
      ab_byp_taken_q <= 1'b0;
    end else begin
      if (a_rise && ab_byp_taken_q) begin
        ab_byp_full_q <= 1'b0;
        ab_byp_taken_q <= 1'b0;
      end
      if (ab_byp_wr) begin
        ab_byp_full_q <= 1'b1;
      end
      if (b_rise && !byp_n_d && ab_byp_full_q && !ab_byp_taken_q && !ab_byp_avail_q) begin
        ab_byp_avail_q <= 1'b1;
      end
      if (ab_byp_rd) begin
        ab_byp_avail_q <= 1'b0;
        ab_byp_taken_q <= 1'b1;
      end
    end
  end

  // B-to-A mirrors the path above with the roles of the two edges swapped.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ba_byp_full_q <= 1'b0;
      ba_byp_avail_q <= 1'b0;
      ba_byp_taken_q <= 1'b0;
    end else if (byp_clr) begin
      ba_byp_full_q <= 1'b0;
      ba_byp_avail_q <= 1'b0;
      ba_byp_taken_q <= 1'b0;
    end else begin
      if (b_rise && ba_byp_taken_q) begin
        ba_byp_full_q <= 1'b0;
        ba_byp_taken_q <= 1'b0;
      end
      if (ba_byp_wr) begin
        ba_byp_full_q <= 1'b1;
      end
      if (a_rise && bypass_a_q && ba_byp_full_q && !ba_byp_taken_q && !ba_byp_avail_q) begin
        ba_byp_avail_q <= 1'b1;
      end
      if (ba_byp_rd) begin
        ba_byp_avail_q <= 1'b0;
        ba_byp_taken_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The two FIFO directions.

  logic [DW-1:0] ab_rd_data, ba_rd_data;
  logic ab_f_e_n, ab_f_ae_n, ab_f_af_n, ab_f_f_n;
  logic ba_f_e_n, ba_f_ae_n, ba_f_af_n, ba_f_f_n;

  dpbfb_fifo #(.DEPTH(DEPTH), .AW(AW), .DW(DW), .OW(OW)) u_ab_fifo (
    .clk(clk),
    .resetn(resetn),
    .clear(soft_clr),
    .wr_en(a_wr & sel_fifo),
    .wr_data(da_s),
    .rd_en(b_rd & ~bypass_b),
    .rd_data(ab_rd_data),
    .ae_off(offs_q[dpbfb_pkg::OFF_AB_AE]),
    .af_off(offs_q[dpbfb_pkg::OFF_AB_AF]),
    .empty_n(ab_f_e_n),
    .almost_empty_n(ab_f_ae_n),
    .almost_full_n(ab_f_af_n),
    .full_n(ab_f_f_n)
  );

  dpbfb_fifo #(.DEPTH(DEPTH), .AW(AW), .DW(DW), .OW(OW)) u_ba_fifo (
    .clk(clk),
    .resetn(resetn),
    .clear(soft_clr),
    .wr_en(b_wr & ~bypass_b),
    .wr_data(db_s),
    .rd_en(a_rd & sel_fifo),
    .rd_data(ba_rd_data),
    .ae_off(offs_q[dpbfb_pkg::OFF_BA_AE]),
    .af_off(offs_q[dpbfb_pkg::OFF_BA_AF]),
    .empty_n(ba_f_e_n),
    .almost_empty_n(ba_f_ae_n),
    .almost_full_n(ba_f_af_n),
    .full_n(ba_f_f_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers and bus drivers.

  logic [DW-1:0] a_out_q, b_out_q;
  logic a_oe_q, b_oe_q;

  // Port-A output register changes only on an enabled read.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_out_q <= '0;
    end else if (a_rd) begin
      if (sel_off) begin
        a_out_q <= DW'(offs_q[off_idx]);
      end else if (sel_fifo && ba_f_e_n) begin
        a_out_q <= ba_rd_data;
      end else if (ba_byp_rd) begin
        a_out_q <= b_in_q;
      end
    end
  end

  // Outside bypass the A-to-B FIFO overwrites whatever bypass word was left.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      b_out_q <= '0;
    end else if (b_rd) begin
      if (ab_byp_rd) begin
        b_out_q <= a_in_q;
      end else if (!bypass_b && ab_f_e_n) begin
        b_out_q <= ab_rd_data;
      end
    end
  end

  // Bus enables follow the synchronised controls; port A drives only while selected.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
    end else begin
      a_oe_q <= a_act & rnw_a_s & ~oe_a_n_s;
      b_oe_q <= rnw_b_s & ~oe_b_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags, each refreshed just after an edge of the side that watches it.

  logic a_tick_q, b_tick_q;
  logic ab_e_n_q, ab_ae_n_q, ab_af_n_q, ab_f_n_q;
  logic ba_e_n_q, ba_ae_n_q, ba_af_n_q, ba_f_n_q;

  // One cycle after the edge the FIFO state already includes that edge's access.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_tick_q <= 1'b0;
      b_tick_q <= 1'b0;
    end else begin
      a_tick_q <= a_rise;
      b_tick_q <= b_rise;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ab_af_n_q <= 1'b1;
      ab_f_n_q <= 1'b1;
      ba_e_n_q <= 1'b0;
      ba_ae_n_q <= 1'b0;
    end else if (soft_clr) begin
      ab_af_n_q <= 1'b1;
      ab_f_n_q <= 1'b1;
      ba_e_n_q <= 1'b0;
      ba_ae_n_q <= 1'b0;
    end else if (a_tick_q) begin
      ab_af_n_q <= ab_f_af_n;
      ab_f_n_q <= bypass_a_q ? ~ab_byp_full_q : ab_f_f_n;
      ba_e_n_q <= bypass_a_q ? ba_byp_avail_q : ba_f_e_n;
      ba_ae_n_q <= ba_f_ae_n;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ab_e_n_q <= 1'b0;
      ab_ae_n_q <= 1'b0;
      ba_af_n_q <= 1'b1;
      ba_f_n_q <= 1'b1;
    end else if (soft_clr) begin
      ab_e_n_q <= 1'b0;
      ab_ae_n_q <= 1'b0;
      ba_af_n_q <= 1'b1;
      ba_f_n_q <= 1'b1;
    end else if (b_tick_q) begin
      ab_e_n_q <= bypass_b ? ab_byp_avail_q : ab_f_e_n;
      ab_ae_n_q <= ab_f_ae_n;
      ba_af_n_q <= ba_f_af_n;
      ba_f_n_q <= bypass_b ? ~ba_byp_full_q : ba_f_f_n;
    end
  end

  assign port_a_data_bus_out = a_out_q;
  assign port_a_data_bus_oe = a_oe_q;
  assign port_b_data_bus_out = b_out_q;
  assign port_b_data_bus_oe = b_oe_q;
  assign bypass_indicator_n = byp_n_q;
  assign ab_empty_n = ab_e_n_q;
  assign ab_almost_empty_n = ab_ae_n_q;
  assign ab_almost_full_n = ab_af_n_q;
  assign ab_full_n = ab_f_n_q;
  assign ba_empty_n = ba_e_n_q;
  assign ba_almost_empty_n = ba_ae_n_q;
  assign ba_almost_full_n = ba_af_n_q;
  assign ba_full_n = ba_f_n_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence ab_byp_write_s;
    ab_byp_wr && !byp_clr ##1 bypass_a_q && !byp_clr && !cs_n_s;
  endsequence

  out_hold_a: assert property (!a_rd |=> $stable(a_out_q))
    else $error("port-A output register changed without a read");
  off_read_a: assert property (a_rd && sel_off |=> a_out_q[DW-1:OW] == '0)
    else $error("offset read returned upper bits");
  cs_ends_byp_a: assert property (cs_n_s |=> byp_n_q && !bypass_a_q)
    else $error("bypass kept while chip select high");
  byp_full_low_a: assert property (ab_byp_write_s |=> !ab_full_n)
    else $error("full flag not low after bypass write");
  byp_block_a: assert property (a_wr && a_byp_now && ab_byp_full_q |=> $stable(a_in_q))
    else $error("bypass write not blocked");
  byp_avail_a: assert property (b_rise && bypass_b && ab_byp_full_q && !ab_byp_taken_q && !byp_clr
                                |=> ab_byp_avail_q || ab_byp_taken_q)
    else $error("bypass word not offered on B edge");
  byp_return_a: assert property (a_rise && ab_byp_taken_q && !ab_byp_wr |=> !ab_byp_full_q)
    else $error("full not released after B took the word");
  byp_leave_a: assert property (b_rise && !cs_n_s && !bypass_a_q |=> byp_n_q)
    else $error("indicator not raised on leaving bypass");

endmodule : dpbfb_top

// *** dpbfb_b_model.sv ***
`timescale 1ns/1ns
// Port-B processor; its clock stands still between accesses.
module dpbfb_b_model (
  input wire logic clk,
  output logic port_b_clock,
  output logic port_b_read_not_write,
  output logic port_b_enable_n,
  output logic port_b_output_enable_n,
  output logic [17:0] port_b_data_bus_in
);
  // Idle, deselected, reading state at time zero.
  initial begin
    {port_b_clock, port_b_read_not_write, port_b_enable_n, port_b_output_enable_n} = 4'h6;
    port_b_data_bus_in = 18'h00000;
  end
  // Controls are held four cycles on each side of the clock pulse, as the pin synchronisers need.
  task automatic b_op(input logic rnw, input logic en_n, input logic [17:0] d);
    @(negedge clk);
    {port_b_read_not_write, port_b_enable_n, port_b_output_enable_n, port_b_data_bus_in} = {rnw, en_n, ~rnw, d};
    repeat (4) @(negedge clk);
    port_b_clock = 1'b1;
    repeat (4) @(negedge clk);
    port_b_clock = 1'b0;
    repeat (4) @(negedge clk);
    port_b_enable_n = 1'b1;
    port_b_data_bus_in = ~d; // A released bus keeps no stale word.
  endtask : b_op
endmodule : dpbfb_b_model

// *** test_dual_port_bidir_fifo_bypass.sv ***
`timescale 1ns/1ns
module test_dual_port_bidir_fifo_bypass;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic a_clk = 1'b0, a_sel_n = 1'b1, a_rnw = 1'b1, a_en_n = 1'b1, a_oe_n = 1'b1;
  logic [2:0] a_rs = 3'h0;
  logic [17:0] a_din = 18'h00000;
  logic [17:0] a_out, b_out, b_din, flags;
  logic a_oe, b_clk, b_rnw, b_en_n, b_oe_n, b_oe, byp_n;
  logic ab_e, ab_ae, ab_af, ab_f, ba_e, ba_ae, ba_af, ba_f;
  int n_fail = 0;
  int n_checks = 0;
  ////////////////////////////////////////////////////////////////////////
  // A small depth keeps fill counts short.
  dpbfb_top #(.DEPTH(16), .AW(4)) u_dut (.clk(clk), .resetn(resetn), .device_reset_n(1'b1),
    .port_a_clock(a_clk), .port_a_select_n(a_sel_n), .port_a_read_not_write(a_rnw),
    .port_a_enable_n(a_en_n), .port_a_output_enable_n(a_oe_n), .port_a_resource_select(a_rs),
    .port_a_data_bus_in(a_din), .port_a_data_bus_out(a_out), .port_a_data_bus_oe(a_oe),
    .port_b_clock(b_clk), .port_b_read_not_write(b_rnw), .port_b_enable_n(b_en_n),
    .port_b_output_enable_n(b_oe_n), .port_b_data_bus_in(b_din), .port_b_data_bus_out(b_out),
    .port_b_data_bus_oe(b_oe), .bypass_indicator_n(byp_n), .ab_empty_n(ab_e), .ab_almost_empty_n(ab_ae),
    .ab_almost_full_n(ab_af), .ab_full_n(ab_f), .ba_empty_n(ba_e), .ba_almost_empty_n(ba_ae),
    .ba_almost_full_n(ba_af), .ba_full_n(ba_f));
  dpbfb_b_model m (.clk(clk), .port_b_clock(b_clk), .port_b_read_not_write(b_rnw), .port_b_enable_n(b_en_n),
    .port_b_output_enable_n(b_oe_n), .port_b_data_bus_in(b_din));
  // All flags packed for one comparison.
  assign flags = {9'h000, ab_e, ab_ae, ab_af, ab_f, ba_e, ba_ae, ba_af, ba_f, byp_n};
  // System clock, 8 ns period.
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One port-A clock; controls held around the rise since pins pass a synchroniser.
  task automatic a_op(input logic sel_n, rnw, en_n, input logic [2:0] rs, input logic [17:0] d);
    @(negedge clk);
    {a_sel_n, a_rnw, a_en_n, a_oe_n, a_rs, a_din} = {sel_n, rnw, en_n, ~rnw, rs, d};
    repeat (4) @(negedge clk);
    a_clk = 1'b1;
    repeat (4) @(negedge clk);
    a_clk = 1'b0;
    repeat (4) @(negedge clk);
  endtask : a_op
  task automatic test_done;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////
  // Offset registers: reset value, upper bits ignored, every code.
  task automatic t_regs;
    chk(flags, 18'h00067);
    for (int i = 0; i < 4; i++) begin
      a_op(1'b0, 1'b1, 1'b0, 3'(4 + i), 18'h00000);
      chk(a_out, 18'h00008);
      a_op(1'b0, 1'b0, 1'b0, 3'(4 + i), 18'h3FE00 | 18'(i + 2));
      a_op(1'b0, 1'b1, 1'b0, 3'(4 + i), 18'h00000);
      chk(a_out, 18'(i + 2));
    end
    chk({17'h0, a_oe}, 18'h00001);
    $display("t_regs done");
  endtask : t_regs
  // FIFO traffic both ways, a disabled read, a deselected write.
  task automatic t_fifo;
    a_op(1'b0, 1'b1, 1'b1, 3'h0, 18'h00000);
    chk(a_out, 18'h00005);
    m.b_op(1'b0, 1'b0, 18'h01234);
    a_op(1'b0, 1'b1, 1'b1, 3'h0, 18'h00000);
    a_op(1'b0, 1'b1, 1'b0, 3'h0, 18'h00000);
    chk(a_out, 18'h01234);
    a_op(1'b0, 1'b0, 1'b0, 3'h0, 18'h2ABCD);
    m.b_op(1'b1, 1'b1, 18'h00000);
    chk(flags, 18'h00167);
    m.b_op(1'b1, 1'b0, 18'h00000);
    chk(b_out, 18'h2ABCD);
    chk({17'h0, b_oe}, 18'h00001);
    a_op(1'b1, 1'b0, 1'b0, 3'h0, 18'h11111);
    m.b_op(1'b1, 1'b1, 18'h00000);
    chk({17'h0, ab_e}, 18'h00000);
    $display("t_fifo done");
  endtask : t_fifo
  // Bypass each way, a blocked second write, exit by deselect.
  task automatic t_byp;
    a_op(1'b0, 1'b1, 1'b1, 3'h1, 18'h00000);
    a_op(1'b0, 1'b0, 1'b0, 3'h1, 18'h15A5A);
    chk({17'h0, ab_f}, 18'h00000);
    a_op(1'b0, 1'b0, 1'b0, 3'h1, 18'h0F0F0);
    m.b_op(1'b1, 1'b1, 18'h00000);
    chk({16'h0, byp_n, ab_e}, 18'h00001);
    m.b_op(1'b1, 1'b0, 18'h00000);
    chk(b_out, 18'h15A5A);
    chk({17'h0, ab_e}, 18'h00000);
    a_op(1'b0, 1'b1, 1'b1, 3'h1, 18'h00000);
    chk({17'h0, ab_f}, 18'h00001);
    m.b_op(1'b0, 1'b0, 18'h2C3C3);
    a_op(1'b0, 1'b1, 1'b1, 3'h1, 18'h00000);
    a_op(1'b0, 1'b1, 1'b0, 3'h1, 18'h00000);
    chk(a_out, 18'h2C3C3);
    a_op(1'b1, 1'b1, 1'b1, 3'h0, 18'h00000);
    chk({17'h0, byp_n}, 18'h00001);
    $display("t_byp done");
  endtask : t_byp
  ////////////////////////////////////////////////////////////////////////
  // Main sequence after a six-cycle reset.
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_fifo();
    t_byp();
    test_done();
  end
  // Watchdog well beyond the roughly 410 cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : test_dual_port_bidir_fifo_bypass
